// *** rtl/valve_actuator_modbus_register_bank.sv ***
/*
  Holding-register bank of a valve actuator controller. Each request word
  comes from the serial frame decoder as one function code, one word address
  and, for writes, one data word; multi-register frames arrive as a run of
  words with req_first marking the first. Every request gets a response one
  cycle later.
  Assumes the frame decoder, the calibration engine, the position loop and
  the fault logic sit outside and are synchronous to core_clk.
*/
`include "valve_bank_regs.svh"

// Summary of operation
// - writing 1 to recalibrate discards stored calibration and starts recalibration
// - writing 1 to low calibration captures the analog reading as low point
// - writing 1 to high calibration captures the analog reading as high point
// - uncaptured calibration points fall back to built-in defaults
// - calibration writes above one are rejected with an exception
// - reserved addresses read zero and accept reads only
// - test register holds 0xB38C from power up
// - position register reports zero to one hundred percent when calibrated
// - position register reads zero while the calibration flag is clear
// - demand register reports the loop demand, zero to one hundred percent
// - low diagnostic byte holds faults; any fault inhibits actuation
// - high diagnostic byte holds operational status flags
// - 32-bit actuation counter over two registers, plus one per travel
// - writable registers take 0x10, 0x06, 0x03; read-only take 0x03 only
// - fault reset write of 1 acts only with a fault; clears on acknowledge
module valve_actuator_modbus_register_bank
  import valve_bank_pkg::*;
#(
  parameter logic [15:0] CAL_LOW_DEFAULT  = `CAL_LOW_DEFAULT,
  parameter logic [15:0] CAL_HIGH_DEFAULT = `CAL_HIGH_DEFAULT
)
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // request word from the frame decoder
  input  wire logic        req_valid,
  input  wire logic [7:0]  req_func,
  input  wire logic [15:0] req_addr,
  input  wire logic [15:0] req_wdata,
  input  wire logic        req_first,
  // response word to the frame builder
  output logic             rsp_valid_q,
  output logic [15:0]      rsp_rdata_q,
  output logic             rsp_exc_q,
  output logic [7:0]       rsp_exc_code_q,
  // actuator state
  input  wire logic [15:0] analog_in,
  input  wire logic [15:0] position_pct,
  input  wire logic [15:0] demand_pct,
  input  wire logic [7:0]  fault_flags,
  input  wire logic [7:0]  status_flags,
  input  wire logic        travel_done,
  input  wire logic        recal_ack,
  input  wire logic        fault_reset_ack,
  // actuator control
  output logic             recal_start_q,
  output logic             recal_pending_q,
  output logic [15:0]      cal_low_q,
  output logic [15:0]      cal_high_q,
  output logic             actuation_inhibit_q,
  output logic             fault_reset_req_q
);

  // reset release through two flops; assertion stays asynchronous
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // bank state
  logic             rsp_valid_d;
  logic [15:0]      rsp_rdata_d;
  logic             rsp_exc_d;
  exc_code_t        rsp_exc_code_d;
  logic             recal_start_d;
  logic             recal_pending_d;
  logic [15:0]      cal_low_d;
  logic [15:0]      cal_high_d;
  logic             cal_low_set_q;
  logic             cal_low_set_d;
  logic             cal_high_set_q;
  logic             cal_high_set_d;
  logic             cal_low_reg_q;
  logic             cal_low_reg_d;
  logic             cal_high_reg_q;
  logic             cal_high_reg_d;
  logic             actuation_inhibit_d;
  logic             fault_reset_req_d;
  logic [31:0]      count_q;
  logic [31:0]      count_d;
  logic [31:0]      snap_q;
  logic [31:0]      snap_d;

  // request decode
  logic             is_read;
  logic             is_write;
  logic             writable;
  logic             readable;
  logic [15:0]      read_word;
  logic [31:0]      count_view;
  logic [15:0]      pos_clamped;
  logic [15:0]      dem_clamped;
  logic             cal_addr;

  // readouts: position forced to zero while uncalibrated, both capped at full scale
  always_comb
  begin
    pos_clamped = (position_pct > `PERCENT_FULL) ? `PERCENT_FULL : position_pct;
    if (!status_flags[`CAL_FLAG_BIT])
      pos_clamped = `ZERO_WORD;
    dem_clamped = (demand_pct > `PERCENT_FULL) ? `PERCENT_FULL : demand_pct;
  end

  // address and function decode
  always_comb
  begin
    is_read    = (req_func == `FC_READ_HOLDING);
    is_write   = (req_func == `FC_WRITE_SINGLE) || (req_func == `FC_WRITE_MULTIPLE);
    cal_addr   = (req_addr == `ADDR_CAL_LOW_POINT) || (req_addr == `ADDR_CAL_HIGH_POINT);
    // the calibration pair overlaps the reserved span and takes precedence there
    writable   = (req_addr == `ADDR_FAULT_RESET) || (req_addr == `ADDR_RECAL_TRIGGER)
                 || cal_addr;
    readable   = writable
                 || ((req_addr >= `ADDR_RESERVED_FIRST) && (req_addr <= `ADDR_COUNT_WORD1));
    // first word of a request sees the live count, later words the snapshot
    count_view = req_first ? count_q : snap_q;
    unique case (req_addr)
      `ADDR_FAULT_RESET:    read_word = {15'h0000, fault_reset_req_q};
      `ADDR_RECAL_TRIGGER:  read_word = {15'h0000, recal_pending_q};
      `ADDR_CAL_LOW_POINT:  read_word = {15'h0000, cal_low_reg_q};
      `ADDR_CAL_HIGH_POINT: read_word = {15'h0000, cal_high_reg_q};
      `ADDR_TEST_PATTERN:   read_word = `TEST_PATTERN_VALUE;
      `ADDR_MEAS_POSITION:  read_word = pos_clamped;
      `ADDR_DEMAND_READOUT: read_word = dem_clamped;
      `ADDR_DIAG_FLAGS:     read_word = {status_flags, fault_flags};
      `ADDR_COUNT_WORD0:    read_word = count_view[15:0];
      `ADDR_COUNT_WORD1:    read_word = count_view[31:16];
      default:              read_word = `ZERO_WORD;
    endcase
  end

  // next values of every register of the bank
  always_comb
  begin
    rsp_valid_d         = req_valid;
    rsp_rdata_d         = `ZERO_WORD;
    rsp_exc_d           = 1'b0;
    rsp_exc_code_d      = EXC_NONE;
    recal_start_d       = 1'b0;
    recal_pending_d     = recal_pending_q;
    cal_low_set_d       = cal_low_set_q;
    cal_high_set_d      = cal_high_set_q;
    cal_low_reg_d       = cal_low_reg_q;
    cal_high_reg_d      = cal_high_reg_q;
    cal_low_d           = cal_low_q;
    cal_high_d          = cal_high_q;
    fault_reset_req_d   = fault_reset_req_q;
    snap_d              = snap_q;
    actuation_inhibit_d = |fault_flags;
    // one step per completed travel, so a full close-open-close adds two
    count_d             = count_q + (travel_done ? `COUNT_STEP : 32'h0000_0000);

    // acknowledges clear pending requests; a new write in the same cycle wins below
    if (recal_ack)
      recal_pending_d = 1'b0;
    if (fault_reset_ack)
      fault_reset_req_d = 1'b0;

    if (req_valid)
    begin
      if (!is_read && !is_write)
      begin
        rsp_exc_d      = 1'b1;
        rsp_exc_code_d = EXC_ILLEGAL_FUNC;
      end
      else if (!readable)
      begin
        rsp_exc_d      = 1'b1;
        rsp_exc_code_d = EXC_ILLEGAL_ADDR;
      end
      else if (is_write && !writable)
      begin
        // read-only and reserved words refuse every write
        rsp_exc_d      = 1'b1;
        rsp_exc_code_d = EXC_ILLEGAL_FUNC;
      end
      else if (is_write && cal_addr && (req_wdata > `TRIGGER_VALUE))
      begin
        rsp_exc_d      = 1'b1;
        rsp_exc_code_d = EXC_ILLEGAL_DATA;
      end
      else if (is_read)
      begin
        rsp_rdata_d = read_word;
        if (req_first && ((req_addr == `ADDR_COUNT_WORD0) || (req_addr == `ADDR_COUNT_WORD1)))
          snap_d = count_q;
      end
      else
      begin
        // accepted write: echo the data word
        rsp_rdata_d = req_wdata;
        unique case (req_addr)
          `ADDR_FAULT_RESET:
          begin
            // without a fault the request is dropped silently
            if ((req_wdata == `TRIGGER_VALUE) && (|fault_flags))
              fault_reset_req_d = 1'b1;
          end
          `ADDR_RECAL_TRIGGER:
          begin
            if (req_wdata == `TRIGGER_VALUE)
            begin
              recal_start_d   = 1'b1;
              recal_pending_d = 1'b1;
              cal_low_set_d   = 1'b0;
              cal_high_set_d  = 1'b0;
              cal_low_reg_d   = 1'b0;
              cal_high_reg_d  = 1'b0;
            end
          end
          `ADDR_CAL_LOW_POINT:
          begin
            cal_low_reg_d = req_wdata[0];
            if (req_wdata[0])
            begin
              cal_low_d     = analog_in;
              cal_low_set_d = 1'b1;
            end
          end
          `ADDR_CAL_HIGH_POINT:
          begin
            cal_high_reg_d = req_wdata[0];
            if (req_wdata[0])
            begin
              cal_high_d     = analog_in;
              cal_high_set_d = 1'b1;
            end
          end
          default:
          begin
            rsp_rdata_d = req_wdata;
          end
        endcase
      end
    end

    // points never captured, or discarded by recalibration, use the defaults
    if (!cal_low_set_d)
      cal_low_d = CAL_LOW_DEFAULT;
    if (!cal_high_set_d)
      cal_high_d = CAL_HIGH_DEFAULT;
  end

  // registers of the bank
  always_ff @(posedge core_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      rsp_valid_q         <= 1'b0;
      rsp_rdata_q         <= `ZERO_WORD;
      rsp_exc_q           <= 1'b0;
      rsp_exc_code_q      <= EXC_NONE;
      recal_start_q       <= 1'b0;
      recal_pending_q     <= 1'b0;
      cal_low_set_q       <= 1'b0;
      cal_high_set_q      <= 1'b0;
      cal_low_reg_q       <= 1'b0;
      cal_high_reg_q      <= 1'b0;
      cal_low_q           <= CAL_LOW_DEFAULT;
      cal_high_q          <= CAL_HIGH_DEFAULT;
      actuation_inhibit_q <= 1'b0;
      fault_reset_req_q   <= 1'b0;
      count_q             <= 32'h0000_0000;
      snap_q              <= 32'h0000_0000;
    end
    else
    begin
      rsp_valid_q         <= rsp_valid_d;
      rsp_rdata_q         <= rsp_rdata_d;
      rsp_exc_q           <= rsp_exc_d;
      rsp_exc_code_q      <= rsp_exc_code_d;
      recal_start_q       <= recal_start_d;
      recal_pending_q     <= recal_pending_d;
      cal_low_set_q       <= cal_low_set_d;
      cal_high_set_q      <= cal_high_set_d;
      cal_low_reg_q       <= cal_low_reg_d;
      cal_high_reg_q      <= cal_high_reg_d;
      cal_low_q           <= cal_low_d;
      cal_high_q          <= cal_high_d;
      actuation_inhibit_q <= actuation_inhibit_d;
      fault_reset_req_q   <= fault_reset_req_d;
      count_q             <= count_d;
      snap_q              <= snap_d;
    end
  end

endmodule

// *** rtl/valve_bank_pkg.sv ***
/*
  Types shared by the valve actuator holding-register bank.
  Assumes the register header sits on the include path.
*/
package valve_bank_pkg;

  // answer codes returned beside each response
  typedef enum logic [7:0]
  {
    EXC_NONE         = 8'h00,
    EXC_ILLEGAL_FUNC = 8'h01,
    EXC_ILLEGAL_ADDR = 8'h02,
    EXC_ILLEGAL_DATA = 8'h03
  } exc_code_t;

endpackage

// *** rtl/valve_bank_regs.svh ***
/*
  Register offsets, function codes and reset values of the
  valve actuator holding-register bank.
  Assumes it is included by bare name from the bank's module.
*/
`ifndef VALVE_BANK_REGS_SVH
`define VALVE_BANK_REGS_SVH

// holding-register offsets (word addresses)
`define ADDR_FAULT_RESET      16'h0001
`define ADDR_RECAL_TRIGGER    16'h0002
`define ADDR_CAL_LOW_POINT    16'h0003
`define ADDR_CAL_HIGH_POINT   16'h0004
`define ADDR_RESERVED_FIRST   16'h0003
`define ADDR_RESERVED_LAST    16'h0007
`define ADDR_TEST_PATTERN     16'h0008
`define ADDR_MEAS_POSITION    16'h0009
`define ADDR_DEMAND_READOUT   16'h000A
`define ADDR_DIAG_FLAGS       16'h000B
`define ADDR_COUNT_WORD0      16'h000C
`define ADDR_COUNT_WORD1      16'h000D

// function codes
`define FC_READ_HOLDING       8'h03
`define FC_WRITE_SINGLE       8'h06
`define FC_WRITE_MULTIPLE     8'h10

// values
`define TEST_PATTERN_VALUE    16'hB38C
`define TRIGGER_VALUE         16'h0001
`define PERCENT_FULL          16'h0064
`define CAL_FLAG_BIT          3'h0
`define ZERO_WORD             16'h0000
`define COUNT_STEP            32'h0000_0001
`define CAL_LOW_DEFAULT       16'h0333
`define CAL_HIGH_DEFAULT      16'h0FFF

`endif

// *** tb/valve_actuator_modbus_register_bank_tb.sv ***
/* self-checking bench of the holding-register bank.
   assumes the checker bind and the actuator model beside it. */
module valve_actuator_modbus_register_bank_tb
  import valve_bank_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, resetn, req_valid, req_first, travel_done;
  logic [7:0]  req_func, fault_flags, status_flags, ack_dly, rsp_exc_code_q;
  logic [15:0] req_addr, req_wdata, analog_in, position_pct, demand_pct, seed;
  logic        rsp_valid_q, rsp_exc_q, recal_start_q, recal_pending_q;
  logic        actuation_inhibit_q, fault_reset_req_q, recal_ack, fault_reset_ack;
  logic [15:0] rsp_rdata_q, cal_low_q, cal_high_q;
  int          err_count, num_checks, n;

  valve_actuator_modbus_register_bank i_dut (.*);
  valve_actuator_model i_model (.*);

  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // readouts saturate at full scale
  function automatic logic [15:0] pct(logic [15:0] v);
    return v > 16'h0064 ? 16'h0064 : v;
  endfunction

  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // request stays up after the answer so calls can run back to back
  task automatic xfer(logic [7:0] f, logic [15:0] a, logic [15:0] d, logic fi,
                      logic [15:0] er, logic [7:0] ec);
    req_valid = 1'b1;
    req_func = f;
    req_addr = a;
    req_wdata = d;
    req_first = fi;
    @(posedge core_clk);
    #1;
    chk("rsp_valid", 16'h0001, {15'h0000, rsp_valid_q});
    chk("rsp_rdata", er, rsp_rdata_q);
    chk("exc_code", {8'h00, ec}, {8'h00, rsp_exc_code_q});
    chk("rsp_exc", {15'h0000, ec != 8'h00}, {15'h0000, rsp_exc_q});
  endtask
  task automatic tick(int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask
  task automatic idle();
    req_valid = 1'b0;
    tick(1);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // the run needs about a hundred cycles; this is far beyond
  initial
  begin
    #100000;
    err_count++;
    wrap_up();
  end

  initial
  begin
    {resetn, req_valid, req_first, travel_done} = 4'h0;
    {req_func, fault_flags, status_flags} = 24'h000000;
    {req_addr, req_wdata, position_pct, demand_pct} = 64'h0;
    analog_in = 16'h1234;
    ack_dly = 8'h02;
    seed = 16'h004E;
    err_count = 0;
    num_checks = 0;
    repeat (8) @(posedge core_clk);
    #1 resetn = 1'b1;
    tick(3);
    chk("cal_low", 16'h0333, cal_low_q);
    chk("cal_high", 16'h0FFF, cal_high_q);
    xfer(8'h03, 16'h0008, seed, 1'b1, 16'hB38C, 8'h00);
    for (int a = 5; a < 8; a++)
      xfer(8'h03, 16'(a), seed, 1'b0, 16'h0000, 8'h00);
    for (int a = 5; a < 14; a++)
      xfer(a % 2 ? 8'h10 : 8'h06, 16'(a), 16'h0001, 1'b1, 16'h0000, 8'h01);
    xfer(8'h2B, 16'h0008, seed, 1'b1, 16'h0000, 8'h01);
    xfer(8'h03, 16'h000E, seed, 1'b1, 16'h0000, 8'h02);
    xfer(8'h06, 16'h0003, 16'h0002, 1'b1, 16'h0000, 8'h03);
    chk("cal_low", 16'h0333, cal_low_q);
    seed = lfsr(seed);
    analog_in = seed;
    xfer(8'h06, 16'h0003, 16'h0001, 1'b1, 16'h0001, 8'h00);
    chk("cal_low", seed, cal_low_q);
    seed = lfsr(seed);
    analog_in = seed;
    xfer(8'h10, 16'h0004, 16'h0001, 1'b1, 16'h0001, 8'h00);
    chk("cal_high", seed, cal_high_q);
    xfer(8'h03, 16'h0003, seed, 1'b1, 16'h0001, 8'h00);
    xfer(8'h06, 16'h0002, 16'h0001, 1'b1, 16'h0001, 8'h00);
    chk("recal_start", 16'h0001, {15'h0000, recal_start_q});
    chk("recal_pending", 16'h0001, {15'h0000, recal_pending_q});
    chk("cal_low", 16'h0333, cal_low_q);
    idle();
    chk("recal_start", 16'h0000, {15'h0000, recal_start_q});
    for (int i = 0; i < 20 && recal_pending_q !== 1'b0; i++)
      tick(1);
    chk("recal_pending", 16'h0000, {15'h0000, recal_pending_q});
    xfer(8'h03, 16'h0002, seed, 1'b1, 16'h0000, 8'h00);
    xfer(8'h03, 16'h0004, seed, 1'b1, 16'h0000, 8'h00);
    xfer(8'h06, 16'h0001, 16'h0001, 1'b1, 16'h0001, 8'h00);
    idle();
    chk("fault_req", 16'h0000, {15'h0000, fault_reset_req_q});
    ack_dly = 8'h09;
    fault_flags = seed[7:0] | 8'h01;
    status_flags = seed[15:8];
    tick(2);
    chk("inhibit", 16'h0001, {15'h0000, actuation_inhibit_q});
    xfer(8'h03, 16'h000B, seed, 1'b1, {status_flags, fault_flags}, 8'h00);
    xfer(8'h06, 16'h0001, 16'h0001, 1'b1, 16'h0001, 8'h00);
    idle();
    chk("fault_req", 16'h0001, {15'h0000, fault_reset_req_q});
    for (int i = 0; i < 20 && fault_reset_req_q !== 1'b0; i++)
      tick(1);
    chk("fault_req", 16'h0000, {15'h0000, fault_reset_req_q});
    fault_flags = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      position_pct = i == 0 ? 16'h0065 : {8'h00, seed[7:0]};
      demand_pct = i == 1 ? 16'h0064 : {8'h00, seed[15:8]};
      status_flags = {seed[3:0], seed[7:5], seed[8]};
      xfer(8'h03, 16'h0009, seed, 1'b1,
           status_flags[0] ? pct(position_pct) : 16'h0000, 8'h00);
      xfer(8'h03, 16'h000A, seed, 1'b1, pct(demand_pct), 8'h00);
    end
    idle();
    n = 2 + seed[2:0];
    repeat (n)
    begin
      travel_done = 1'b1;
      tick(1);
      travel_done = 1'b0;
      tick(1);
    end
    xfer(8'h03, 16'h000C, seed, 1'b1, 16'(n), 8'h00);
    travel_done = 1'b1;
    xfer(8'h03, 16'h000D, seed, 1'b0, 16'h0000, 8'h00);
    travel_done = 1'b0;
    // the count has moved on by now; a non-first read must still see the snapshot
    xfer(8'h03, 16'h000C, seed, 1'b0, 16'(n), 8'h00);
    idle();
    xfer(8'h03, 16'h000C, seed, 1'b1, 16'(n + 1), 8'h00);
    idle();
    wrap_up();
  end
endmodule

// *** tb/valve_actuator_model.sv ***
/* calibration engine and fault logic seen from the bank.
   assumes the bank holds each request level until acknowledged. */
module valve_actuator_model
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       resetn,
  // answer delay, prompt or slow
  input  wire logic [7:0] ack_dly,
  // requests and acknowledges
  input  wire logic       recal_pending_q,
  input  wire logic       fault_reset_req_q,
  output logic            recal_ack,
  output logic            fault_reset_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rc_q;
  logic [7:0] fc_q;
  // one pulse per held request; the count clears once the request drops
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rc_q <= 8'h00;
      fc_q <= 8'h00;
      recal_ack <= 1'b0;
      fault_reset_ack <= 1'b0;
    end
    else
    begin
      rc_q <= recal_pending_q ? rc_q + 8'h01 : 8'h00;
      fc_q <= fault_reset_req_q ? fc_q + 8'h01 : 8'h00;
      recal_ack <= recal_pending_q && rc_q == ack_dly;
      fault_reset_ack <= fault_reset_req_q && fc_q == ack_dly;
    end
  end
endmodule

// *** tb/valve_bank_chk.sv ***
/* port assertions for the holding-register bank.
   assumes one clock and the bind below. */
module valve_bank_chk
  import valve_bank_pkg::*;
(
  // clock and reset
  input wire logic        core_clk,
  input wire logic        resetn,
  // request and response
  input wire logic        req_valid,
  input wire logic [7:0]  req_func,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_wdata,
  input wire logic        rsp_valid_q,
  input wire logic [15:0] rsp_rdata_q,
  input wire logic        rsp_exc_q,
  input wire logic [7:0]  rsp_exc_code_q,
  // actuator side
  input wire logic [15:0] analog_in,
  input wire logic [15:0] demand_pct,
  input wire logic [7:0]  fault_flags,
  input wire logic [7:0]  status_flags,
  input wire logic        recal_start_q,
  input wire logic [15:0] cal_low_q,
  input wire logic        actuation_inhibit_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // request kinds and clipped demand
  wire        rd = req_valid && req_func == 8'h03;
  wire        wr = req_valid && (req_func == 8'h06 || req_func == 8'h10);
  wire [15:0] dm = demand_pct > 16'h0064 ? 16'h0064 : demand_pct;

  chk_answer_one_cycle: assert property (req_valid |=> rsp_valid_q)
    else $error("response missing");
  chk_test_pattern: assert property (rd && req_addr == 16'h0008 |=>
    rsp_rdata_q == 16'hB38C && !rsp_exc_q) else $error("test pattern");
  chk_reserved_zero: assert property (rd && req_addr inside {[16'h0005:16'h0007]}
    |=> rsp_rdata_q == 16'h0000 && !rsp_exc_q) else $error("reserved read");
  chk_ro_write_refused: assert property (wr && req_addr inside {[16'h0005:16'h000D]}
    |=> rsp_exc_q && rsp_exc_code_q == 8'h01) else $error("read-only write");
  chk_cal_range: assert property (wr && req_addr inside {16'h0003, 16'h0004} &&
    req_wdata > 16'h0001 |=> rsp_exc_code_q == 8'h03) else $error("cal range");
  chk_cal_capture: assert property (wr && req_addr == 16'h0003 &&
    req_wdata == 16'h0001 |=> cal_low_q == $past(analog_in)) else $error("capture");
  chk_pos_uncal: assert property (rd && req_addr == 16'h0009 && !status_flags[0]
    |=> rsp_rdata_q == 16'h0000) else $error("uncal position");
  chk_demand_clip: assert property (rd && req_addr == 16'h000A
    |=> rsp_rdata_q == $past(dm)) else $error("demand readout");
  chk_recal_pulse: assert property (wr && req_addr == 16'h0002 &&
    req_wdata == 16'h0001 |=> recal_start_q ##1 !recal_start_q) else $error("recal");
  chk_fault_inhibit: assert property (1'b1 |=>
    actuation_inhibit_q == ($past(fault_flags) != 8'h00)) else $error("inhibit");
  // main scenarios reached
  cover property (rd && req_addr == 16'h000C);
  cover property (recal_start_q);
  cover property (rsp_exc_q && rsp_exc_code_q == 8'h03);
endmodule

bind valve_actuator_modbus_register_bank valve_bank_chk i_chk (.*);
